// >>> gpx_pin_model.sv
// Pin model: resolves each pad from port drive, an outside driver and pull-up.
// Assumes the outside driver yields wherever the port drives.
`timescale 1ns/1ns
module gpx_pin_model (
    input wire logic clk,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_i
);
    // A floating pad flips every cycle so no settled value is mistaken for a level.
    always_ff @(posedge clk) begin
        pin_i <= (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
            | (~pin_oe & ~ext_en & (pin_pullup | ~pin_i));
    end
endmodule : gpx_pin_model

// >>> gpx_pkg.sv
// Package for the 8-pin general-purpose port with external interrupt requests.
// Assumes a Wishbone classic slave with 32-bit data, byte addresses, one register per word.
package gpx_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_DIR = 4'h4;
    localparam logic [3:0] ADDR_OPT = 4'h8;
    localparam logic [3:0] ADDR_SENS = 4'hc;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_OPT = 8'h00;
    localparam logic [1:0] RST_SENS = 2'h0;

    // ==========================================================
    // Sensitivity encodings
    localparam logic [1:0] SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] SENS_RISE = 2'h1;
    localparam logic [1:0] SENS_FALL = 2'h2;
    localparam logic [1:0] SENS_BOTH = 2'h3;

    // ==========================================================
    // Pin kinds: 0 standard, 1 interrupt with pull-up, 2 interrupt floating
    localparam logic [15:0] PIN_KIND = 16'h0015;

    typedef enum logic [3:0] {
        MODE_FLOAT = 4'h1,
        MODE_PULLUP = 4'h2,
        MODE_OPEN_DRAIN = 4'h4,
        MODE_PUSH_PULL = 4'h8
    } gpx_mode_t;

endpackage : gpx_pkg

// >>> gpx_port.sv
// Eight-pin general-purpose port with per-pin direction, option, data latch,
// alternate-function override and one ORed external interrupt request.
// Assumes asynchronous pin inputs and a CPU that acknowledges the vector fetch.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module gpx_port (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    // Pins
    input wire logic [7:0] PIN_I,
    output logic [7:0] PIN_O,
    output logic [7:0] PIN_OE,
    output logic [7:0] PIN_PULLUP,
    // Peripheral alternate functions
    input wire logic [7:0] ALT_OUT_EN,
    input wire logic [7:0] ALT_OUT_VAL,
    input wire logic [7:0] ALT_OPEN_DRAIN,
    output logic [7:0] ALT_IN,
    // CPU side of the interrupt
    input wire logic CPU_INT_MASK,
    input wire logic VECTOR_FETCH,
    output logic EXT_IRQ,
    output logic WAKE_REQ
);

    // ==========================================================
    // Registers
    logic [7:0] pin_data_latch_reg;
    logic [7:0] pin_direction_reg;
    logic [7:0] pin_option_reg;
    logic [1:0] sensitivity_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] prev_reg;
    logic pending_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;

    function automatic logic [1:0] pin_kind(input int idx);
        pin_kind = gpx_pkg::PIN_KIND[idx*2 +: 2];
    endfunction : pin_kind

    function automatic gpx_pkg::gpx_mode_t decode_mode(input logic dir, input logic opt);
        case ({dir, opt})
            2'h0: decode_mode = gpx_pkg::MODE_FLOAT;
            2'h1: decode_mode = gpx_pkg::MODE_PULLUP;
            2'h2: decode_mode = gpx_pkg::MODE_OPEN_DRAIN;
            2'h3: decode_mode = gpx_pkg::MODE_PUSH_PULL;
            default: decode_mode = gpx_pkg::MODE_FLOAT;
        endcase
    endfunction : decode_mode

    // ==========================================================
    // Bus decode
    logic req;
    logic wr_en;
    logic hit;
    assign req = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
    assign hit = (WB_ADR_I == gpx_pkg::ADDR_DATA) || (WB_ADR_I == gpx_pkg::ADDR_DIR) ||
                 (WB_ADR_I == gpx_pkg::ADDR_OPT) || (WB_ADR_I == gpx_pkg::ADDR_SENS);
    // A write lands on the edge where the master samples ack high, so a master
    // that gives up before that edge leaves the registers untouched.
    assign wr_en = WB_CYC_I && WB_STB_I && ack_reg && hit && WB_WE_I && WB_SEL_I[0];

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= req && hit;
            err_reg <= req && !hit;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            pin_data_latch_reg <= gpx_pkg::RST_DATA;
            pin_direction_reg <= gpx_pkg::RST_DIR;
            pin_option_reg <= gpx_pkg::RST_OPT;
            sensitivity_reg <= gpx_pkg::RST_SENS;
        end else if (wr_en) begin
            case (WB_ADR_I)
                gpx_pkg::ADDR_DATA: pin_data_latch_reg <= WB_DAT_I[7:0];
                gpx_pkg::ADDR_DIR: pin_direction_reg <= WB_DAT_I[7:0];
                gpx_pkg::ADDR_OPT: pin_option_reg <= WB_DAT_I[7:0];
                gpx_pkg::ADDR_SENS: sensitivity_reg <= WB_DAT_I[1:0];
                default: sensitivity_reg <= sensitivity_reg;
            endcase
        end
    end

    // ==========================================================
    // Pin input synchroniser; the first stage feeds only the second.
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            prev_reg <= 8'h00;
        end else begin
            sync1_reg <= PIN_I;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // ==========================================================
    // Pin drive, alternate functions and per-pin interrupt enables
    logic [7:0] read_val;
    logic [7:0] irq_en;
    logic [7:0] detect;
    always_comb begin
        gpx_pkg::gpx_mode_t m;
        m = gpx_pkg::MODE_FLOAT;
        for (int i = 0; i < 8; i++) begin
            m = decode_mode(pin_direction_reg[i], pin_option_reg[i]);
            PIN_PULLUP[i] = 1'b0;
            irq_en[i] = 1'b0;
            if (ALT_OUT_EN[i]) begin
                // Peripheral drive wins over the programmed mode.
                PIN_O[i] = ALT_OUT_VAL[i];
                PIN_OE[i] = !ALT_OPEN_DRAIN[i] || !ALT_OUT_VAL[i];
            end else if (pin_direction_reg[i]) begin
                PIN_O[i] = pin_data_latch_reg[i];
                PIN_OE[i] = (m == gpx_pkg::MODE_PUSH_PULL) || !pin_data_latch_reg[i];
            end else begin
                PIN_O[i] = 1'b0;
                PIN_OE[i] = 1'b0;
                PIN_PULLUP[i] = (m == gpx_pkg::MODE_PULLUP) && (pin_kind(i) != 2'h2);
                irq_en[i] = (m == gpx_pkg::MODE_PULLUP) && (pin_kind(i) != 2'h0);
            end
            if (pin_direction_reg[i] && !ALT_OUT_EN[i]) begin
                read_val[i] = pin_data_latch_reg[i];
            end else if (ALT_OUT_EN[i]) begin
                read_val[i] = ALT_OUT_VAL[i];
            end else begin
                read_val[i] = sync2_reg[i];
            end
            ALT_IN[i] = pin_direction_reg[i] ? pin_data_latch_reg[i] : sync2_reg[i];
            case (sensitivity_reg)
                gpx_pkg::SENS_FALL_LOW: detect[i] = !sync2_reg[i];
                gpx_pkg::SENS_RISE: detect[i] = sync2_reg[i] && !prev_reg[i];
                gpx_pkg::SENS_FALL: detect[i] = !sync2_reg[i] && prev_reg[i];
                gpx_pkg::SENS_BOTH: detect[i] = sync2_reg[i] != prev_reg[i];
                default: detect[i] = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Request latch; software cannot see it, a sensitivity write cancels it.
    logic any_event;
    logic sens_write;
    assign any_event = |(detect & irq_en);
    assign sens_write = wr_en && (WB_ADR_I == gpx_pkg::ADDR_SENS);

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            pending_reg <= 1'b0;
        end else if (sens_write) begin
            pending_reg <= 1'b0;
        end else if (any_event) begin
            pending_reg <= 1'b1; // Set wins over the fetch clear.
        end else if (VECTOR_FETCH) begin
            pending_reg <= 1'b0;
        end
    end

    assign EXT_IRQ = pending_reg && !CPU_INT_MASK;
    // Wake-up ignores the mask: wait and halt unmask interrupts on entry.
    assign WAKE_REQ = pending_reg;

    // ==========================================================
    // Read data
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req && !WB_WE_I) begin
            case (WB_ADR_I)
                gpx_pkg::ADDR_DATA: rdata_reg <= {24'h000000, read_val};
                gpx_pkg::ADDR_DIR: rdata_reg <= {24'h000000, pin_direction_reg};
                gpx_pkg::ADDR_OPT: rdata_reg <= {24'h000000, pin_option_reg};
                gpx_pkg::ADDR_SENS: rdata_reg <= {30'h00000000, sensitivity_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign WB_DAT_O = rdata_reg;
    assign WB_ACK_O = ack_reg;
    assign WB_ERR_O = err_reg;

endmodule : gpx_port

// >>> gpx_port_sva.sv
// Checker for the eight-pin port, watching only the top module's ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
module gpx_port_sva (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic WB_ACK_O,
    input wire logic WB_ERR_O,
    // Pins and alternate functions
    input wire logic [7:0] PIN_O,
    input wire logic [7:0] PIN_OE,
    input wire logic [7:0] PIN_PULLUP,
    input wire logic [7:0] ALT_OUT_EN,
    input wire logic [7:0] ALT_OUT_VAL,
    input wire logic [7:0] ALT_OPEN_DRAIN,
    // Interrupt
    input wire logic CPU_INT_MASK,
    input wire logic VECTOR_FETCH,
    input wire logic EXT_IRQ,
    input wire logic WAKE_REQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property ((WB_ACK_O || WB_ERR_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("bus answer without a request");
    a_alt_drive: assert property ((ALT_OUT_EN & ~ALT_OPEN_DRAIN & ~PIN_OE) == 8'h00)
        else $error("claimed push-pull pin not driven");
    a_alt_float: assert property ((ALT_OUT_EN & ALT_OPEN_DRAIN & ALT_OUT_VAL & PIN_OE) == 8'h00)
        else $error("open-drain high is driven");
    a_alt_value: assert property ((ALT_OUT_EN & PIN_OE & (PIN_O ^ ALT_OUT_VAL)) == 8'h00)
        else $error("claimed pin drives wrong value");
    a_pullup_input: assert property ((PIN_PULLUP & PIN_OE) == 8'h00)
        else $error("pull-up on a driven pin");
    a_irq_mask: assert property (EXT_IRQ == (WAKE_REQ && !CPU_INT_MASK))
        else $error("request mask mismatch");
    a_pend_clear: assert property ($fell(WAKE_REQ) |-> $past(VECTOR_FETCH)
        || $past(WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 4'hc)) else $error("request lost");
endmodule : gpx_port_sva

// >>> gpx_port_tb_top.sv
// Testbench for the eight-pin port: bus tasks, pin model, interrupt sequences.
// Assumes every request is answered; the bus task waits any number of cycles for ack or err.
`timescale 1ns/1ns
module gpx_port_tb_top;
    logic clk = 1'b0, nrst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, mask = 1'b0, fetch = 1'b0, err;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic [7:0] pin_i, pin_o, pin_oe, pin_pu, alt_in, q, ext_en = 8'hff, ext_val = 8'hff;
    logic [7:0] alt_en = 8'h00, alt_val = 8'h00, alt_od = 8'h00;
    logic ack, irq, wake, bus_err;
    int error_cnt = 0, n_checks = 0;
    gpx_port DUT (.CORE_CLK(clk), .NRST(nrst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .WB_ERR_O(err), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu),
        .ALT_OUT_EN(alt_en), .ALT_OUT_VAL(alt_val), .ALT_OPEN_DRAIN(alt_od), .ALT_IN(alt_in),
        .CPU_INT_MASK(mask), .VECTOR_FETCH(fetch), .EXT_IRQ(irq), .WAKE_REQ(wake));
    gpx_pin_model u_pins (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup(pin_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
    initial forever #50 clk = ~clk;
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
        do @(posedge clk); while (!(ack || err));
        q = dat_o[7:0];
        bus_err = err;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask : settle
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        settle(8);
        nrst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wb(4'(i * 4), 1'b0, 8'h00);
            chk("reset value", 8'h00, q);
        end
        wb(4'h1, 1'b0, 8'h00);
        chk("unmapped err", 8'h01, {7'h0, bus_err});
        ext_val <= 8'h3c;
        wb(gpx_pkg::ADDR_DATA, 1'b1, 8'ha5);
        chk("input oe", 8'h00, pin_oe);
        wb(gpx_pkg::ADDR_DATA, 1'b0, 8'h00);
        chk("input read", 8'h3c, q);
        wb(gpx_pkg::ADDR_OPT, 1'b1, 8'h0f);
        wb(gpx_pkg::ADDR_DIR, 1'b1, 8'hff);
        chk("output oe", 8'h5f, pin_oe);
        chk("output drive", 8'h05, pin_o & pin_oe);
        chk("alt input", 8'ha5, alt_in);
        wb(gpx_pkg::ADDR_DATA, 1'b0, 8'h00);
        chk("latch read", 8'ha5, q);
        wb(gpx_pkg::ADDR_OPT, 1'b1, 8'hf0);
        wb(gpx_pkg::ADDR_DIR, 1'b1, 8'h00);
        chk("pull-up", 8'hf0, pin_pu);
        alt_en <= 8'h81; alt_val <= 8'h81; alt_od <= 8'h80;
        settle(4);
        chk("alt oe", 8'h01, pin_oe);
        wb(gpx_pkg::ADDR_DATA, 1'b0, 8'h00);
        chk("alt read", 8'hbd, q);
        alt_en <= 8'h00; ext_val <= 8'hff;
        wb(gpx_pkg::ADDR_OPT, 1'b1, 8'h27);
        wb(gpx_pkg::ADDR_SENS, 1'b1, {6'h0, gpx_pkg::SENS_FALL});
        ext_val <= 8'hdf;
        settle(8);
        chk("standard pin", 8'h00, {7'h0, wake});
        ext_val <= 8'hdd;
        for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
        chk("request", 8'h01, {7'h0, wake});
        chk("irq", 8'h01, {7'h0, irq});
        mask <= 1'b1;
        settle(2);
        chk("masked irq", 8'h00, {7'h0, irq});
        mask <= 1'b0; fetch <= 1'b1;
        settle(1);
        fetch <= 1'b0;
        settle(2);
        chk("fetch clear", 8'h00, {7'h0, wake});
        ext_val <= 8'hd9;
        settle(8);
        chk("second pin", 8'h01, {7'h0, wake});
        wb(gpx_pkg::ADDR_SENS, 1'b1, {6'h0, gpx_pkg::SENS_FALL});
        settle(1);
        chk("sens clear", 8'h00, {7'h0, wake});
        report_and_stop();
    end
    initial begin
        settle(3000);
        error_cnt++;
        report_and_stop();
    end
endmodule : gpx_port_tb_top
bind gpx_port gpx_port_sva u_sva (.CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O),
    .WB_ERR_O(WB_ERR_O), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
    .ALT_OUT_EN(ALT_OUT_EN), .ALT_OUT_VAL(ALT_OUT_VAL), .ALT_OPEN_DRAIN(ALT_OPEN_DRAIN),
    .CPU_INT_MASK(CPU_INT_MASK), .VECTOR_FETCH(VECTOR_FETCH), .EXT_IRQ(EXT_IRQ), .WAKE_REQ(WAKE_REQ));
